// >>> rtl/dcm_pkg.sv
// Constants, types and operation decode for the data cache miss port
// Notes on behaviour
// [RULE1] Read request: select pair gives 4/2/1 words
// [RULE2] Write request: same pair gives 4/2/1 words
// [RULE3] Both requests: partial write word/half/byte
// [RULE4] Busy output high during RAM access or hold
// [RULE5] Read retry output tells cache to retry
// [RULE6] Uncached flag low in cache-enabled area
// [RULE7] Refill ready marks fetched refill data
// [RULE8] Cache marks its read data valid
// [RULE9] Hit-under-miss data overtakes pending refill
// [RULE10] Cache gives 28-bit miss address
// [RULE11] Shared bus: refill in, write-back out
// [RULE12] Cache raises access request before op code
// [RULE13] Address acknowledge once miss address taken
// [RULE14] Rising-edge timing, request held until acknowledge
// [RULE15] Device drives data bus only for refill
`default_nettype none
package dcm_pkg;
   localparam int ADDR_W     = 28;
   localparam int DATA_W     = 32;
   localparam int BE_W       = 4;
   localparam int CNT_W      = 3;
   localparam int FIFO_DEPTH = 4;
   localparam int REGION_W   = 3;
   localparam int REGIONS    = 8;
   localparam int REGION_LSB = 25;
   localparam logic [ADDR_W-1:0] WORD_STEP  = 28'h0000004;
   localparam logic [ADDR_W-1:0] WORD_ALIGN = 28'hffffffc;
   localparam logic [CNT_W-1:0]  WORDS_FOUR = 3'h4;
   localparam logic [CNT_W-1:0]  WORDS_TWO  = 3'h2;
   localparam logic [CNT_W-1:0]  WORDS_ONE  = 3'h1;
   localparam logic [BE_W-1:0]   BE_WORD    = 4'hf;
   localparam logic [BE_W-1:0]   BE_HALF    = 4'h3;
   localparam logic [BE_W-1:0]   BE_BYTE    = 4'h1;

   typedef enum logic [1:0] {
      DCM_OP_NONE, DCM_OP_READ, DCM_OP_WRITE, DCM_OP_PART
   } dcm_op_e;

   typedef enum logic [2:0] {
      DCM_IDLE, DCM_READ, DCM_WDATA, DCM_WMEM, DCM_DRAIN
   } dcm_state_e;

   // Operation type; prohibited codes decode to none
   function automatic dcm_op_e dcm_decode(input logic rd, input logic wr,
                                          input logic s4, input logic s2);
      dcm_op_e op;
      op = DCM_OP_NONE;
      if (rd && !wr && !(s4 && s2))
         op = DCM_OP_READ;
      else if (!rd && wr && !(s4 && s2))
         op = DCM_OP_WRITE;
      else if (rd && wr && !(!s4 && s2))
         op = DCM_OP_PART;
      return op;
   endfunction

   // Sequential length from the select pair
   function automatic logic [CNT_W-1:0] dcm_words(input logic s4,
                                                  input logic s2);
      return s4 ? WORDS_FOUR : (s2 ? WORDS_TWO : WORDS_ONE);
   endfunction

   // Byte lanes of a partial write from size and low address
   function automatic logic [BE_W-1:0] dcm_part_be(input logic s4,
                                                   input logic s2,
                                                   input logic [1:0] a);
      logic [BE_W-1:0] be;
      be = BE_WORD;
      if (s4 && !s2)
         be = BE_HALF << {a[1], 1'b0};
      else if (!s4 && !s2)
         be = BE_BYTE << a;
      return be;
   endfunction
endpackage
`default_nettype wire

// >>> rtl/dcm_fifo.sv
// Refill word buffer with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module dcm_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 4
) (
   input  wire logic             clk_i,       // Core bus clock
   input  wire logic             resetn_i,    // Sync reset, low
   input  wire logic             in_valid_i,  // Word offered
   output logic                  in_ready_o,  // Room for a word
   input  wire logic [WIDTH-1:0] in_data_i,   // Word in
   output logic                  out_valid_o, // Word available
   input  wire logic             out_ready_i, // Word taken
   output logic [WIDTH-1:0]      out_data_o   // Oldest word
);
   localparam int AW = $clog2(DEPTH);

   // Refused at elaboration: pointer wrap only works for powers of two
   if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_depth_bad
      $error("dcm_fifo: DEPTH must be a power of two, at least 2");
   end

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW:0]                 wp;
      logic [AW:0]                 rp;
   } dcm_fifo_s;

   dcm_fifo_s s;
   dcm_fifo_s next_s;

   // Extra pointer bit tells full from empty without a counter
   assign in_ready_o  = !((s.wp[AW] != s.rp[AW]) &&
                          (s.wp[AW-1:0] == s.rp[AW-1:0]));
   assign out_valid_o = s.wp != s.rp;
   assign out_data_o  = s.mem[s.rp[AW-1:0]];

   // Pointer and storage update
   always_comb begin
      next_s = s;
      if (in_valid_i && in_ready_o) begin
         next_s.mem[s.wp[AW-1:0]] = in_data_i;
         next_s.wp = s.wp + 1'b1;
      end
      if (out_valid_o && out_ready_i)
         next_s.rp = s.rp + 1'b1;
   end

   // Only the pointers need a reset value
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         s.mem <= s.mem;
         s.wp  <= '0;
         s.rp  <= '0;
      end else begin
         s <= next_s;
      end
   end
endmodule
`default_nettype wire

// >>> rtl/dcm_miss_port.sv
// Device end of the data cache miss port with refill path
`timescale 1ns/1ps
`default_nettype none
module dcm_miss_port #(
   parameter int FIFO_DEPTH = dcm_pkg::FIFO_DEPTH
) (
   input  wire logic        CORE_CLK_I,              // Core bus clock
   input  wire logic        RESETN_I,                // Sync reset, low
   input  wire logic        CACHE_READ_REQUEST_I,    // Read op request
   input  wire logic        CACHE_WRITE_REQUEST_I,   // Write op request
   input  wire logic        SEQ_SELECT_FOUR_I,       // Select pair, first
   input  wire logic        SEQ_SELECT_TWO_I,        // Select pair, second
   input  wire logic [27:0] MISS_ADDRESS_I,          // Miss byte address
   input  wire logic        HIT_UNDER_MISS_I,        // Hit data overtakes
   input  wire logic        CACHE_READ_DATA_READY_I, // Cache data valid
   input  wire logic [31:0] CACHE_DATA_BUS_I,        // Data bus, in
   output logic [31:0]      CACHE_DATA_BUS_O,        // Data bus, out
   output logic             CACHE_DATA_BUS_OE_O,     // Data bus enable
   output logic             ADDRESS_ACKNOWLEDGE_O,   // Address taken
   output logic             REFILL_READY_O,          // Refill word on bus
   output logic             READ_RETRY_REQUEST_O,    // Retry the read
   output logic             UNCACHED_AREA_FLAG_O,    // Area not cached
   output logic             LOCAL_RAM_BUS_BUSY_O,    // Local bus busy
   output logic             ACCESS_REQUEST_O,        // Core wants access
   input  wire logic        CORE_ACCESS_I,           // Core access wish
   input  wire logic [7:0]  CACHE_CONFIG_I,          // Per-region enable
   input  wire logic        LOCAL_DATA_BUS_RAM_I,    // Local bus at RAM
   input  wire logic        LOCAL_DATA_BUS_HOLD_I,   // Local bus held
   output logic             MEM_REQ_O,               // Memory request
   output logic             MEM_WRITE_O,             // Memory write
   output logic [27:0]      MEM_ADDR_O,              // Memory address
   output logic [3:0]       MEM_BE_O,                // Memory byte lanes
   output logic [31:0]      MEM_WDATA_O,             // Memory write data
   input  wire logic        MEM_ACK_I,               // Memory done
   input  wire logic        MEM_ERR_I,               // Memory failed
   input  wire logic [31:0] MEM_RDATA_I,             // Memory read data
   output logic [31:0]      HIT_DATA_O,              // Hit data to core
   output logic             HIT_VALID_O              // Hit data strobe
);
   // Refused at elaboration, before any logic is built
   if (FIFO_DEPTH < 2) begin : g_depth_bad
      $error("dcm_miss_port: FIFO_DEPTH below 2");
   end

   typedef struct packed {
      dcm_pkg::dcm_state_e             st;
      logic [dcm_pkg::ADDR_W-1:0]      addr;
      logic [dcm_pkg::CNT_W-1:0]       left;
      logic [dcm_pkg::BE_W-1:0]        be;
      logic [dcm_pkg::DATA_W-1:0]      wdata;
      logic [dcm_pkg::DATA_W-1:0]      rdata;
      logic [dcm_pkg::DATA_W-1:0]      hit_data;
      logic                            drive;
      logic                            ack;
      logic                            retry;
      logic                            unch;
      logic                            hit_valid;
      logic                            acc_req;
   } dcm_port_s;

   dcm_port_s        s;
   dcm_port_s        next_s;
   dcm_pkg::dcm_op_e op;
   logic             fifo_in_ready;
   logic             fifo_out_valid;
   logic             fifo_pop;
   logic             fifo_push;
   logic [31:0]      fifo_out_data;
   logic [dcm_pkg::REGION_W-1:0] region;

   // Requests sampled on the rising edge, decoded here
   assign op = dcm_pkg::dcm_decode(CACHE_READ_REQUEST_I,
                                   CACHE_WRITE_REQUEST_I,
                                   SEQ_SELECT_FOUR_I,
                                   SEQ_SELECT_TWO_I); // RULE1 RULE2 RULE3
   assign region = MISS_ADDRESS_I[dcm_pkg::REGION_LSB +: dcm_pkg::REGION_W];

   // Hit data has the bus, so refill words wait behind it
   assign fifo_pop  = fifo_out_valid && !HIT_UNDER_MISS_I; // RULE9
   assign fifo_push = (s.st == dcm_pkg::DCM_READ) && MEM_ACK_I;

   // Memory handshake; a read waits for room so the buffer never overruns
   assign MEM_REQ_O   = ((s.st == dcm_pkg::DCM_READ) && fifo_in_ready) ||
                        (s.st == dcm_pkg::DCM_WMEM);
   assign MEM_WRITE_O = s.st == dcm_pkg::DCM_WMEM;
   assign MEM_ADDR_O  = s.addr;
   assign MEM_BE_O    = s.be;
   assign MEM_WDATA_O = s.wdata;

   assign LOCAL_RAM_BUS_BUSY_O = LOCAL_DATA_BUS_RAM_I ||
                                 LOCAL_DATA_BUS_HOLD_I; // RULE4
   assign CACHE_DATA_BUS_O      = s.rdata;
   assign CACHE_DATA_BUS_OE_O   = s.drive; // RULE15 RULE11
   assign REFILL_READY_O        = s.drive; // RULE7
   assign ADDRESS_ACKNOWLEDGE_O = s.ack;
   assign READ_RETRY_REQUEST_O  = s.retry;
   assign UNCACHED_AREA_FLAG_O  = s.unch;
   assign ACCESS_REQUEST_O      = s.acc_req;
   assign HIT_DATA_O            = s.hit_data;
   assign HIT_VALID_O           = s.hit_valid;

   dcm_fifo #(
      .WIDTH (dcm_pkg::DATA_W),
      .DEPTH (FIFO_DEPTH)
   ) u_refill_fifo (
      .clk_i       (CORE_CLK_I),
      .resetn_i    (RESETN_I),
      .in_valid_i  (fifo_push),
      .in_ready_o  (fifo_in_ready),
      .in_data_i   (MEM_RDATA_I),
      .out_valid_o (fifo_out_valid),
      .out_ready_i (fifo_pop),
      .out_data_o  (fifo_out_data)
   );

   // Sequencer, refill output stage and hit capture
   always_comb begin
      next_s = s;
      next_s.ack       = 1'b0;
      next_s.retry     = 1'b0;
      next_s.acc_req   = CORE_ACCESS_I;
      next_s.drive     = fifo_pop; // RULE15
      next_s.hit_valid = HIT_UNDER_MISS_I && CACHE_READ_DATA_READY_I; // RULE9
      if (fifo_pop)
         next_s.rdata = fifo_out_data; // RULE11
      if (next_s.hit_valid)
         next_s.hit_data = CACHE_DATA_BUS_I;
      unique case (s.st)
         dcm_pkg::DCM_IDLE: begin
            // Prohibited codes are never acknowledged
            if (op != dcm_pkg::DCM_OP_NONE) begin
               next_s.ack  = 1'b1; // RULE13 RULE14
               next_s.unch = !CACHE_CONFIG_I[region]; // RULE6
               next_s.addr = MISS_ADDRESS_I & dcm_pkg::WORD_ALIGN;
               next_s.left = dcm_pkg::dcm_words(SEQ_SELECT_FOUR_I,
                                                SEQ_SELECT_TWO_I);
               next_s.be   = dcm_pkg::BE_WORD;
               if (op == dcm_pkg::DCM_OP_READ) begin
                  next_s.st = dcm_pkg::DCM_READ; // RULE1
               end else if (op == dcm_pkg::DCM_OP_WRITE) begin
                  next_s.st = dcm_pkg::DCM_WDATA; // RULE2
               end else begin
                  next_s.left = dcm_pkg::WORDS_ONE;
                  next_s.be   = dcm_pkg::dcm_part_be(SEQ_SELECT_FOUR_I,
                                   SEQ_SELECT_TWO_I,
                                   MISS_ADDRESS_I[1:0]); // RULE3
                  next_s.st   = dcm_pkg::DCM_WDATA;
               end
            end
         end
         dcm_pkg::DCM_READ: begin
            if (MEM_ACK_I) begin
               next_s.addr = s.addr + dcm_pkg::WORD_STEP;
               next_s.left = s.left - 1'b1;
               // A failed fetch abandons the burst and asks for a retry
               if (MEM_ERR_I) begin
                  next_s.retry = 1'b1; // RULE5
                  next_s.st    = dcm_pkg::DCM_DRAIN;
               end else if (s.left == dcm_pkg::WORDS_ONE) begin
                  next_s.st = dcm_pkg::DCM_DRAIN;
               end
            end
         end
         dcm_pkg::DCM_WDATA: begin
            // Write-back word comes from the cache; hit data is not ours
            if (CACHE_READ_DATA_READY_I && !HIT_UNDER_MISS_I) begin
               next_s.wdata = CACHE_DATA_BUS_I; // RULE11
               next_s.st    = dcm_pkg::DCM_WMEM;
            end
         end
         dcm_pkg::DCM_WMEM: begin
            if (MEM_ACK_I) begin
               next_s.addr = s.addr + dcm_pkg::WORD_STEP;
               next_s.left = s.left - 1'b1;
               next_s.st   = (s.left == dcm_pkg::WORDS_ONE) ?
                             dcm_pkg::DCM_IDLE : dcm_pkg::DCM_WDATA;
            end
         end
         dcm_pkg::DCM_DRAIN: begin
            if (!fifo_out_valid)
               next_s.st = dcm_pkg::DCM_IDLE;
         end
         default: next_s.st = dcm_pkg::DCM_IDLE;
      endcase
   end

   // State register
   always_ff @(posedge CORE_CLK_I) begin
      if (!RESETN_I)
         s <= '0;
      else
         s <= next_s;
   end

   default clocking cb @(posedge CORE_CLK_I); endclocking
   default disable iff (!RESETN_I);

   sequence s_take(dcm_pkg::dcm_op_e o);
      s.st == dcm_pkg::DCM_IDLE && op == o;
   endsequence
   sequence s_four;
      SEQ_SELECT_FOUR_I && !SEQ_SELECT_TWO_I;
   endsequence

   chk_ack_single: assert property (ADDRESS_ACKNOWLEDGE_O |=> // RULE13
      !ADDRESS_ACKNOWLEDGE_O)
      else $error("acknowledge longer than one cycle");
   chk_no_ack_bad: assert property (s.st == dcm_pkg::DCM_IDLE && // RULE1
      op == dcm_pkg::DCM_OP_NONE |=> !ADDRESS_ACKNOWLEDGE_O)
      else $error("prohibited code acknowledged");
   chk_read_four: assert property (s_take(dcm_pkg::DCM_OP_READ) ##0 // RULE1
      s_four |=> s.left == dcm_pkg::WORDS_FOUR &&
      s.st == dcm_pkg::DCM_READ)
      else $error("four-word read not set up");
   chk_write_four: assert property (s_take(dcm_pkg::DCM_OP_WRITE) // RULE2
      ##0 s_four |=> s.left == dcm_pkg::WORDS_FOUR &&
      s.st == dcm_pkg::DCM_WDATA)
      else $error("four-word write not set up");
   chk_part_byte: assert property (s_take(dcm_pkg::DCM_OP_PART) ##0 // RULE3
      !SEQ_SELECT_FOUR_I |=>
      MEM_BE_O == (dcm_pkg::BE_BYTE << $past(MISS_ADDRESS_I[1:0])))
      else $error("byte lanes wrong for byte write");
   chk_busy_level: assert property (LOCAL_DATA_BUS_HOLD_I |-> // RULE4
      LOCAL_RAM_BUS_BUSY_O)
      else $error("busy low while bus held");
   chk_retry_cause: assert property (READ_RETRY_REQUEST_O |-> // RULE5
      $past(s.st == dcm_pkg::DCM_READ && MEM_ERR_I))
      else $error("retry without failed read");
   chk_uncached_flag: assert property (ADDRESS_ACKNOWLEDGE_O |-> // RULE6
      UNCACHED_AREA_FLAG_O == !$past(CACHE_CONFIG_I[region]))
      else $error("uncached flag wrong");
   chk_refill_word: assert property (fifo_pop |=> REFILL_READY_O && // RULE7
      CACHE_DATA_BUS_O == $past(fifo_out_data))
      else $error("refill word not presented");
   chk_hum_first: assert property (HIT_UNDER_MISS_I |=> // RULE9
      !CACHE_DATA_BUS_OE_O)
      else $error("refill drove bus during hit data");
   chk_wb_release: assert property (s.st == dcm_pkg::DCM_WDATA && // RULE15
      !fifo_out_valid |=> !CACHE_DATA_BUS_OE_O)
      else $error("bus driven during write-back");
endmodule
`default_nettype wire

// >>> tb/dcm_cache_model.sv
// Data cache side model: operation requests, write data, hit data
`timescale 1ns/1ps
`default_nettype none
module dcm_cache_model (
   input  wire logic        clk_i,    // Core bus clock
   input  wire logic        ack_i,    // Address acknowledge
   input  wire logic        dev_oe_i, // Device drives bus
   input  wire logic [31:0] dev_d_i,  // Device bus value
   output logic             rd_o,     // Read request
   output logic             wr_o,     // Write request
   output logic             s4_o,     // Select, first
   output logic             s2_o,     // Select, second
   output logic [27:0]      addr_o,   // Miss address
   output logic             hum_o,    // Hit under miss
   output logic             rdy_o,    // Cache data valid
   output logic [31:0]      bus_o     // Resolved bus level
);
   logic        c_oe;
   logic [31:0] c_d;
   logic [31:0] last;

   // Undriven bus toggles, so a stale word can never pass as data
   assign bus_o = dev_oe_i ? dev_d_i : (c_oe ? c_d : ~last);
   always @(posedge clk_i) last <= bus_o;

   // Quiet outputs from time zero
   initial begin
      {rd_o, wr_o, s4_o, s2_o, hum_o, rdy_o, c_oe} = 7'h00;
      addr_o = 28'h0000000;
      c_d = 32'h00000000;
      last = 32'h00000000;
   end

   // Code and address held until acknowledge is sampled high, or for at most 20 edges
   task automatic req(input logic [3:0] c, input logic [27:0] a,
                      output bit ok);
      ok = 1'b0;
      @(posedge clk_i);
      #1;
      {rd_o, wr_o, s4_o, s2_o} = c;
      addr_o = a;
      for (int n = 0; n < 20 && !ok; n++) begin
         @(posedge clk_i);
         ok = (ack_i === 1'b1);
      end
      #1;
      {rd_o, wr_o, s4_o, s2_o} = 4'h0;
      addr_o = ~a;
   endtask

   // One word with valid; also serves hit data under HUM
   task automatic wdata(input logic [31:0] d);
      @(posedge clk_i);
      #1;
      c_oe = 1'b1;
      c_d = d;
      rdy_o = 1'b1;
      @(posedge clk_i);
      #1;
      c_oe = 1'b0;
      rdy_o = 1'b0;
   endtask

   // Raised a cycle ahead of hit data so no refill word collides
   task automatic hum(input logic v);
      @(posedge clk_i);
      #1;
      hum_o = v;
   endtask
endmodule
`default_nettype wire

// >>> tb/dcm_miss_port_tb.sv
// Self-checking bench for the data cache miss port
`timescale 1ns/1ps
`default_nettype none
module dcm_miss_port_tb;
   logic        clk, rstn, ram, hold, acc, m_ack, m_err, err_on;
   logic        rd, wr, s4, s2, hum, rdy, oe, aack, rrdy, retry, unc;
   logic        busy, areq, m_req, m_wr, hv;
   logic [27:0] addr, m_addr;
   logic [31:0] bus, dout, m_rd, m_wd, hd;
   logic [3:0]  m_be;
   logic [64:0] mq [$];
   logic [31:0] rq [$];
   logic [31:0] hq [$];
   int          error_cnt, total_checks, mw;
   int          nw [3] = '{4, 2, 1};
   localparam logic [7:0] CFG = 8'h05;

   dcm_miss_port #(.FIFO_DEPTH(4)) dut (
      .CORE_CLK_I(clk), .RESETN_I(rstn), .CACHE_READ_REQUEST_I(rd),
      .CACHE_WRITE_REQUEST_I(wr), .SEQ_SELECT_FOUR_I(s4),
      .SEQ_SELECT_TWO_I(s2), .MISS_ADDRESS_I(addr),
      .HIT_UNDER_MISS_I(hum), .CACHE_READ_DATA_READY_I(rdy),
      .CACHE_DATA_BUS_I(bus), .CACHE_DATA_BUS_O(dout),
      .CACHE_DATA_BUS_OE_O(oe), .ADDRESS_ACKNOWLEDGE_O(aack),
      .REFILL_READY_O(rrdy), .READ_RETRY_REQUEST_O(retry),
      .UNCACHED_AREA_FLAG_O(unc), .LOCAL_RAM_BUS_BUSY_O(busy),
      .ACCESS_REQUEST_O(areq), .CORE_ACCESS_I(acc), .CACHE_CONFIG_I(CFG),
      .LOCAL_DATA_BUS_RAM_I(ram), .LOCAL_DATA_BUS_HOLD_I(hold),
      .MEM_REQ_O(m_req), .MEM_WRITE_O(m_wr), .MEM_ADDR_O(m_addr),
      .MEM_BE_O(m_be), .MEM_WDATA_O(m_wd), .MEM_ACK_I(m_ack),
      .MEM_ERR_I(m_err), .MEM_RDATA_I(m_rd), .HIT_DATA_O(hd),
      .HIT_VALID_O(hv));

   dcm_cache_model cm (.clk_i(clk), .ack_i(aack), .dev_oe_i(oe),
      .dev_d_i(dout), .rd_o(rd), .wr_o(wr), .s4_o(s4), .s2_o(s2),
      .addr_o(addr), .hum_o(hum), .rdy_o(rdy), .bus_o(bus));

   always #20 clk = ~clk;

   // Memory word pattern derived from its address
   function automatic logic [31:0] rdf(input logic [27:0] a);
      return {4'h5, a};
   endfunction

   task automatic fail(input string m);
      error_cnt++;
      $display("[FAIL] %0t %s", $time, m);
   endtask

   task automatic chk(input bit c, input string m);
      total_checks++;
      if (!c) fail(m);
   endtask

   task automatic wrap_up();
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // Loggers sample at the edge; memory answers just after it
   always @(posedge clk) begin
      if (m_req === 1'b1 && m_ack) mq.push_back({m_wr, m_addr, m_be, m_wd});
      if (oe === 1'b1) rq.push_back(dout);
      if (hv === 1'b1) hq.push_back(hd);
      if (oe === 1'b1 && cm.c_oe) fail("bus driven twice");
      if (oe !== rrdy) fail("ready differs from enable");
      #1;
      if (m_ack) begin
         m_ack = 1'b0;
         m_rd = ~m_rd;
      end else if (m_req === 1'b1) begin
         mw++;
         if (mw == 2) begin
            mw = 0;
            m_ack = 1'b1;
            m_err = err_on;
            m_rd = rdf(m_addr);
         end
      end
   end

   // Bounded wait for logged words; a hang ends the run
   task automatic waitq(input int n, input bit m);
      for (int j = 0; j < 300; j++) begin
         if ((m ? mq.size() : rq.size()) >= n) return;
         @(posedge clk);
         #1;
      end
      fail("wait timed out");
      wrap_up();
   endtask

   task automatic clear();
      rq.delete();
      mq.delete();
      hq.delete();
   endtask

   task automatic t_busy();
      for (int i = 0; i < 4; i++) begin
         @(posedge clk);
         #1;
         {ram, hold} = i[1:0];
         #5;
         chk(busy === (i != 0), "busy level");
      end
      {ram, hold} = 2'h0;
   endtask

   task automatic t_access();
      @(posedge clk);
      #1;
      acc = 1'b1;
      chk(areq === 1'b0, "access early");
      @(posedge clk);
      #1;
      acc = 1'b0;
      chk(areq === 1'b1, "access late");
   endtask

   task automatic t_read();
      logic [3:0]  c [3] = '{4'ha, 4'h9, 4'h8};
      logic [27:0] a;
      bit          ok;
      for (int i = 0; i < 3; i++) begin
         a = {i[2:0], 25'h0000040};
         cm.req(c[i], a, ok);
         chk(ok, "read not acknowledged");
         chk(unc === ~CFG[i], "uncached flag");
         waitq(nw[i], 0);
         for (int k = 0; k < nw[i]; k++) begin
            chk(rq[k] === rdf(a + 28'(4 * k)), "refill word");
            chk(mq[k][64:36] === {1'b0, a + 28'(4 * k)}, "fetch");
         end
         clear();
      end
   endtask

   task automatic t_write();
      logic [3:0]  c [3] = '{4'h6, 4'h5, 4'h4};
      logic [27:0] a;
      logic [31:0] d;
      bit          ok;
      for (int i = 0; i < 3; i++) begin
         a = 28'h0000100 + 28'(i * 16);
         cm.req(c[i], a, ok);
         chk(ok, "write not acknowledged");
         for (int k = 0; k < nw[i]; k++) begin
            d = {4'ha, a + 28'(4 * k)};
            cm.wdata(d);
            waitq(k + 1, 1);
            chk(mq[k] === {1'b1, a + 28'(4 * k), 4'hf, d}, "wbeat");
         end
         clear();
      end
   endtask

   task automatic t_part();
      logic [3:0] c [3] = '{4'hf, 4'he, 4'hc};
      logic [1:0] lo [3] = '{2'h0, 2'h2, 2'h1};
      logic [3:0] be [3] = '{4'hf, 4'hc, 4'h2};
      bit         ok;
      for (int i = 0; i < 3; i++) begin
         cm.req(c[i], {26'h200, lo[i]}, ok);
         chk(ok, "partial not acknowledged");
         cm.wdata(32'h12345678);
         waitq(1, 1);
         chk(mq[0][64] === 1'b1 && mq[0][35:32] === be[i], "lanes");
         clear();
      end
   endtask

   // Prohibited codes must never be acknowledged or reach memory
   task automatic t_bad();
      logic [3:0] c [4] = '{4'hb, 4'h7, 4'hd, 4'h3};
      bit         ok;
      for (int i = 0; i < 4; i++) begin
         cm.req(c[i], 28'h0000040, ok);
         chk(!ok && mq.size() == 0, "prohibited code taken");
      end
   endtask

   task automatic t_retry();
      bit ok;
      bit seen;
      seen = 1'b0;
      err_on = 1'b1;
      cm.req(4'ha, 28'h0000080, ok);
      chk(ok, "retry read not acknowledged");
      for (int j = 0; j < 40 && !seen; j++) begin
         @(posedge clk);
         seen = (retry === 1'b1);
      end
      chk(seen, "no retry");
      err_on = 1'b0;
      repeat (12) @(posedge clk);
      clear();
   endtask

   // HUM held: buffer fills to depth, hit data goes first, then drain
   task automatic t_hum();
      bit ok;
      cm.hum(1'b1);
      cm.req(4'ha, 28'h0000300, ok);
      chk(ok, "hum read not acknowledged");
      waitq(4, 1);
      repeat (4) @(posedge clk);
      chk(rq.size() == 0, "refill under hum");
      cm.wdata(32'hcafe0001);
      @(posedge clk);
      #1;
      chk(hq.size() == 1 && hq[0] === 32'hcafe0001, "hit data");
      chk(rq.size() == 0, "refill overtook hit");
      cm.hum(1'b0);
      waitq(4, 0);
      for (int k = 0; k < 4; k++)
         chk(rq[k] === rdf(28'h0000300 + 28'(4 * k)), "drain");
      clear();
   endtask

   initial begin
      {clk, rstn, ram, hold, acc, m_ack, m_err, err_on} = 8'h00;
      m_rd = 32'h00000000;
      repeat (12) @(posedge clk);
      #1;
      rstn = 1'b1;
      t_busy();
      t_access();
      t_read();
      t_write();
      t_part();
      t_bad();
      t_retry();
      t_hum();
      wrap_up();
   end
endmodule
`default_nettype wire
